/* File: isdm_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
module isdm_far_end (
  // Requests from the bench
  input  wire logic [23:0]         req,
  input  wire logic [1:0]          pin_pol,
  // Source pins
  output isdm_pkg::isdm_int_src_t  int_src,
  output logic                     ext_a,
  output logic                     ext_b,
  output logic [10:0]              dev_irq
);
  import isdm_pkg::*;
  // Internal sources, active high
  assign int_src = isdm_int_src_t'(req[23:3]);
  // Pins driven in their own polarity
  assign ext_a = req[1] ^ pin_pol[0];
  assign ext_b = req[2] ^ pin_pol[1];
  assign dev_irq = {10'h0, req[0]};
endmodule
`default_nettype wire

/* File: isdm_irq_map.sv */
`timescale 1ns/1ns
`default_nettype none
`include "isdm_regs.svh"
module isdm_irq_map #(
  parameter int NUM_DEV = 11
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register bus, write address and data
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // Register bus, write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Register bus, read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Interrupt sources
  input  wire isdm_pkg::isdm_int_src_t int_src,
  input  wire logic                  ext_input_irq_a,
  input  wire logic                  ext_input_irq_b,
  input  wire logic [NUM_DEV-1:0]    dev_irq,
  // Interrupt destinations
  output logic                       proc_irq_line_a,
  output logic                       proc_irq_line_b,
  output logic                       ext_output_irq_a,
  output logic                       ext_output_irq_b
);
  import isdm_pkg::*;

  localparam logic [31:0] DEV_MASK = 32'((64'h1 << NUM_DEV) - 64'h1);

  isdm_state_t q;
  isdm_state_t n;
  logic [3:0][23:0] dst_ident;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sticky set events per trigger code {hi,lo}
  function automatic logic [31:0] isdm_detect(
    input logic [31:0] cur,
    input logic [31:0] prv,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    logic [31:0] rise;
    logic [31:0] fall;
    rise = cur & ~prv;
    fall = ~cur & prv;
    isdm_detect = (~hi & ~lo & cur) | (~hi & lo & (rise | fall))
                | (hi & ~lo & fall) | (hi & lo & rise);
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] isdm_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  strb
  );
    logic [31:0] bm;
    bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    isdm_merge = (old & ~bm) | (wd & bm);
  endfunction

  // Address decode
  function automatic logic isdm_mapped(input logic [7:0] a);
    isdm_mapped = (a[1:0] == 2'h0) && (a <= `ISDM_OFS_EXT_DST_POL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Per-destination view

  genvar gd;
  generate
    for (gd = 0; gd < 4; gd++)
    begin : g_dst
      assign dst_ident[gd] = q.map[gd] & ((q.bypass & q.prev) | (~q.bypass & q.sticky)) & q.ena;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [31:0] dev_raw;
    logic [31:0] dev_ev;
    logic [31:0] dev_eff;
    logic [31:0] dev_idt;
    logic [23:0] src;
    logic [23:0] ev;
    logic [23:0] eff;
    logic [23:0] idt;
    logic [23:0] clr;
    logic [23:0] frc;
    logic [31:0] dev_clr;
    logic [31:0] bm;
    logic [31:0] rd;
    logic        wr;
    dev_raw = 32'h0;
    dev_ev  = 32'h0;
    dev_eff = 32'h0;
    dev_idt = 32'h0;
    src     = 24'h0;
    ev      = 24'h0;
    eff     = 24'h0;
    idt     = 24'h0;
    clr     = 24'h0;
    frc     = 24'h0;
    dev_clr = 32'h0;
    bm      = 32'h0;
    rd      = 32'h0;
    wr      = 1'b0;
    n       = q;

    // Port module hierarchy, polarity fixed at entry
    dev_raw = (32'(dev_irq) ^ q.dev_pol) & DEV_MASK;
    dev_ev  = isdm_detect(dev_raw, q.dev_prev, q.dev_trig_lo, q.dev_trig_hi);
    dev_eff = (q.dev_bypass & dev_raw) | (~q.dev_bypass & q.dev_sticky);
    dev_idt = dev_eff & q.dev_ena & DEV_MASK;

    // Source vector assembly
    src[`ISDM_BIT_PORT_AGG]  = |dev_idt;
    src[`ISDM_BIT_EXT_A]     = ext_input_irq_a ^ q.ext_src_pol[0];
    src[`ISDM_BIT_EXT_B]     = ext_input_irq_b ^ q.ext_src_pol[1];
    src[`ISDM_BIT_TMR_A]     = int_src.gp_tmr_a_irq;
    src[`ISDM_BIT_TMR_B]     = int_src.gp_tmr_b_irq;
    src[`ISDM_BIT_TMR_C]     = int_src.gp_tmr_c_irq;
    src[`ISDM_BIT_SER_A]     = int_src.first_serial_port_irq;
    src[`ISDM_BIT_SER_B]     = int_src.second_serial_port_irq;
    src[`ISDM_BIT_TWO_WIRE]  = int_src.two_wire_irq;
    src[`ISDM_BIT_SER_MST]   = int_src.serial_master_irq;
    src[`ISDM_BIT_SOFT_A]    = int_src.soft_irq_a;
    src[`ISDM_BIT_SOFT_B]    = int_src.soft_irq_b;
    src[`ISDM_BIT_SER_PIN]   = int_src.serial_pin_irq;
    src[`ISDM_BIT_PAR_PIN]   = int_src.parallel_pin_irq;
    src[`ISDM_BIT_MGMT_A]    = int_src.mgmt_ctrl_a_irq;
    src[`ISDM_BIT_MGMT_B]    = int_src.mgmt_ctrl_b_irq;
    src[`ISDM_BIT_FRAME_DMA_IRQ]      = int_src.frame_dma_irq;
    src[`ISDM_BIT_ANALYZER]  = int_src.analyzer_irq;
    src[`ISDM_BIT_TS_RDY]    = int_src.timestamp_ready_irq;
    src[`ISDM_BIT_TM_SYNC]   = int_src.time_master_sync_irq;
    src[`ISDM_BIT_MEM_INTEG] = int_src.memory_integrity_irq;
    src[`ISDM_BIT_EXTRACTION_READY_IRQ]   = int_src.extraction_ready_irq;
    src[`ISDM_BIT_INJECTION_READY_IRQ]   = int_src.injection_ready_irq;
    src[`ISDM_BIT_PCIE_PM]   = int_src.pcie_power_irq;

    ev  = 24'(isdm_detect({8'h00, src}, {8'h00, q.prev}, {8'h00, q.trig_lo}, {8'h00, q.trig_hi}));
    eff = (q.bypass & src) | (~q.bypass & q.sticky);
    idt = eff & q.ena;

    // Write channel
    if (s_axi_awvalid && q.awready)
    begin
      n.awaddr  = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
      n.wready = 1'b0;
    end
    wr = !q.awready && !q.wready && !q.bvalid;
    bm = isdm_merge(32'h0, 32'hffff_ffff, q.wstrb);
    if (wr)
    begin
      n.bvalid = 1'b1;
      n.bresp  = isdm_mapped(q.awaddr) ? `ISDM_RESP_OKAY : `ISDM_RESP_SLVERR;
      case (q.awaddr)
        `ISDM_OFS_BYPASS:      n.bypass      = 24'(isdm_merge({8'h00, q.bypass}, q.wdata, q.wstrb));
        `ISDM_OFS_TRIG_LO:     n.trig_lo     = 24'(isdm_merge({8'h00, q.trig_lo}, q.wdata, q.wstrb));
        `ISDM_OFS_TRIG_HI:     n.trig_hi     = 24'(isdm_merge({8'h00, q.trig_hi}, q.wdata, q.wstrb));
        `ISDM_OFS_FORCE:       frc           = 24'(q.wdata & bm);
        `ISDM_OFS_STICKY:      clr           = 24'(q.wdata & bm);
        `ISDM_OFS_ENA:         n.ena         = 24'(isdm_merge({8'h00, q.ena}, q.wdata, q.wstrb));
        `ISDM_OFS_ENA_CLR:     n.ena         = q.ena & ~24'(q.wdata & bm);
        `ISDM_OFS_ENA_SET:     n.ena         = q.ena | 24'(q.wdata & bm);
        `ISDM_OFS_DEV_POL:     n.dev_pol     = isdm_merge(q.dev_pol, q.wdata, q.wstrb) & DEV_MASK;
        `ISDM_OFS_DEV_BYPASS:  n.dev_bypass  = isdm_merge(q.dev_bypass, q.wdata, q.wstrb) & DEV_MASK;
        `ISDM_OFS_DEV_TRIG_LO: n.dev_trig_lo = isdm_merge(q.dev_trig_lo, q.wdata, q.wstrb) & DEV_MASK;
        `ISDM_OFS_DEV_TRIG_HI: n.dev_trig_hi = isdm_merge(q.dev_trig_hi, q.wdata, q.wstrb) & DEV_MASK;
        `ISDM_OFS_DEV_STICKY:  dev_clr       = q.wdata & bm;
        `ISDM_OFS_DEV_ENA:     n.dev_ena     = isdm_merge(q.dev_ena, q.wdata, q.wstrb) & DEV_MASK;
        `ISDM_OFS_EXT_SRC_POL: n.ext_src_pol = 2'(isdm_merge({30'h0, q.ext_src_pol}, q.wdata, q.wstrb));
        `ISDM_OFS_EXT_DST_POL: n.ext_dst_pol = 2'(isdm_merge({30'h0, q.ext_dst_pol}, q.wdata, q.wstrb));
        default:
        begin
          for (int d = 0; d < 4; d++)
          begin
            if (q.awaddr == `ISDM_OFS_MAP0 + 8'(d * 4))
            begin
              n.map[d] = 24'(isdm_merge({8'h00, q.map[d]}, q.wdata, q.wstrb));
            end
          end
        end
      endcase
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // Sticky update, set wins over clear
    n.sticky     = (q.sticky & ~clr) | ev | frc;
    n.dev_sticky = ((q.dev_sticky & ~dev_clr) | dev_ev) & DEV_MASK;
    n.prev       = src;
    n.dev_prev   = dev_raw;

    // Destinations, registered
    for (int d = 0; d < 4; d++)
    begin
      n.dst[d] = |(idt & q.map[d]);
    end
    n.ext_pin[0] = n.dst[`ISDM_DST_EXT_A] ^ q.ext_dst_pol[0];
    n.ext_pin[1] = n.dst[`ISDM_DST_EXT_B] ^ q.ext_dst_pol[1];

    // Read channel
    case (s_axi_araddr)
      `ISDM_OFS_RAW:         rd = {8'h00, q.prev};
      `ISDM_OFS_BYPASS:      rd = {8'h00, q.bypass};
      `ISDM_OFS_TRIG_LO:     rd = {8'h00, q.trig_lo};
      `ISDM_OFS_TRIG_HI:     rd = {8'h00, q.trig_hi};
      `ISDM_OFS_STICKY:      rd = {8'h00, q.sticky};
      `ISDM_OFS_ENA:         rd = {8'h00, q.ena};
      `ISDM_OFS_IDENT:       rd = {8'h00, (q.bypass & q.prev | ~q.bypass & q.sticky) & q.ena};
      `ISDM_OFS_DEV_POL:     rd = q.dev_pol;
      `ISDM_OFS_DEV_RAW:     rd = q.dev_prev;
      `ISDM_OFS_DEV_BYPASS:  rd = q.dev_bypass;
      `ISDM_OFS_DEV_TRIG_LO: rd = q.dev_trig_lo;
      `ISDM_OFS_DEV_TRIG_HI: rd = q.dev_trig_hi;
      `ISDM_OFS_DEV_STICKY:  rd = q.dev_sticky;
      `ISDM_OFS_DEV_ENA:     rd = q.dev_ena;
      `ISDM_OFS_DEV_IDENT:   rd = ((q.dev_bypass & q.dev_prev) | (~q.dev_bypass & q.dev_sticky)) & q.dev_ena;
      `ISDM_OFS_EXT_SRC_POL: rd = {30'h0, q.ext_src_pol};
      `ISDM_OFS_EXT_DST_POL: rd = {30'h0, q.ext_dst_pol};
      default:
      begin
        for (int d = 0; d < 4; d++)
        begin
          if (s_axi_araddr == `ISDM_OFS_MAP0 + 8'(d * 4))
          begin
            rd = {8'h00, q.map[d]};
          end
          if (s_axi_araddr == `ISDM_OFS_DIDENT0 + 8'(d * 4))
          begin
            rd = {8'h00, dst_ident[d]};
          end
        end
      end
    endcase
    if (s_axi_arvalid && q.arready)
    begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = rd;
      n.rresp   = isdm_mapped(s_axi_araddr) ? `ISDM_RESP_OKAY : `ISDM_RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_arready    = q.arready;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign proc_irq_line_a  = q.dst[`ISDM_DST_PROC_A];
  assign proc_irq_line_b  = q.dst[`ISDM_DST_PROC_B];
  assign ext_output_irq_a = q.ext_pin[0];
  assign ext_output_irq_b = q.ext_pin[1];

endmodule
`default_nettype wire

/* File: isdm_irq_map_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "isdm_regs.svh"
module isdm_irq_map_bench;
  import isdm_pkg::*;
  logic          clk = 1'h0;
  logic          rst = 1'h1;
  logic [7:0]    s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]    s_axi_wstrb = 4'hf, dst;
  logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic          s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs, dpol = 2'h0, pin_pol = 2'h0;
  isdm_int_src_t int_src;
  logic          ext_input_irq_a, ext_input_irq_b;
  logic [10:0]   dev_irq;
  logic          proc_irq_line_a, proc_irq_line_b, ext_output_irq_a, ext_output_irq_b;
  logic [23:0]   req = 24'h0;
  logic [23:0]   map_m [4];
  int            mismatches = 0, check_count = 0, cyc = 0;
  assign dst = {ext_output_irq_b, ext_output_irq_a, proc_irq_line_b, proc_irq_line_a};
  always #50 clk = ~clk;
  isdm_far_end far (
    .req     (req),
    .pin_pol (pin_pol),
    .int_src (int_src),
    .ext_a   (ext_input_irq_a),
    .ext_b   (ext_input_irq_b),
    .dev_irq (dev_irq)
  );
  isdm_irq_map dut (.*);
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (t < 40)
    begin
      @(posedge clk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (!(s_axi_bvalid && s_axi_bready))
    begin
      mismatches++;
      $display("[ERR] %0t write timeout", $time);
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (t < 40)
    begin
      @(posedge clk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (!(s_axi_rvalid && s_axi_rready))
    begin
      mismatches++;
      $display("[ERR] %0t read timeout", $time);
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    chk(rv, exp, what);
  endtask
  // Model of the four destinations
  function automatic logic [3:0] dst_exp(input logic [23:0] s);
    for (int d = 0; d < 4; d++) dst_exp[d] = |(map_m[d] & s);
    dst_exp[3:2] = dst_exp[3:2] ^ dpol;
  endfunction
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(98401));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdchk(`ISDM_OFS_ENA, 32'h0, "ena reset");
    rdchk(`ISDM_OFS_MAP0, 32'h0, "map reset");
    rdchk(8'h70, 32'h0, "unmapped data");
    chk(rs, 2'h2, "unmapped resp");
    wr(8'h70, 32'hffffffff);
    chk(rs, 2'h2, "unmapped write");
    $display("test reset done");
    for (int d = 0; d < 4; d++)
    begin
      map_m[d] = 24'($urandom);
      wr(8'(`ISDM_OFS_MAP0 + 4 * d), {8'h0, map_m[d]});
    end
    wr(`ISDM_OFS_ENA, 32'hffffff);
    wr(`ISDM_OFS_DEV_ENA, 32'h1);
    for (int n = 0; n < 24; n++)
    begin
      req <= 24'h1 << n;
      repeat (4) @(posedge clk);
      chk(dst, dst_exp(24'h1 << n), "dest on");
      rdchk(`ISDM_OFS_STICKY, 32'h1 << n, "position");
      rdchk(`ISDM_OFS_RAW, 32'h1 << n, "raw");
      rdchk(`ISDM_OFS_DIDENT0, {8'h0, map_m[0] & (24'h1 << n)}, "dst ident");
      req <= 24'h0;
      wr(`ISDM_OFS_DEV_STICKY, 32'h1);
      wr(`ISDM_OFS_STICKY, 32'h1 << n);
      repeat (4) @(posedge clk);
      chk(dst, 4'h0, "dest off");
    end
    $display("test positions done");
    wr(`ISDM_OFS_EXT_SRC_POL, 32'h3);
    pin_pol <= 2'h3;
    wr(`ISDM_OFS_STICKY, 32'hffffff);
    req <= 24'h4;
    repeat (4) @(posedge clk);
    rdchk(`ISDM_OFS_STICKY, 32'h4, "low pin");
    wr(`ISDM_OFS_EXT_DST_POL, 32'h3);
    dpol = 2'h3;
    repeat (4) @(posedge clk);
    chk(dst, dst_exp(24'h4), "dest pol");
    req <= 24'h0;
    wr(`ISDM_OFS_EXT_SRC_POL, 32'h0);
    pin_pol <= 2'h0;
    wr(`ISDM_OFS_EXT_DST_POL, 32'h0);
    dpol = 2'h0;
    wr(`ISDM_OFS_STICKY, 32'hffffff);
    $display("test polarity done");
    for (int c = 0; c < 4; c++)
    begin
      wr(`ISDM_OFS_TRIG_LO, 32'(c & 1) << 3);
      wr(`ISDM_OFS_TRIG_HI, 32'(c >> 1) << 3);
      wr(`ISDM_OFS_STICKY, 32'h8);
      req <= 24'h8;
      repeat (4) @(posedge clk);
      rdchk(`ISDM_OFS_STICKY, (c == 2) ? 32'h0 : 32'h8, "edge on");
      wr(`ISDM_OFS_STICKY, 32'h8);
      rdchk(`ISDM_OFS_STICKY, (c == 0) ? 32'h8 : 32'h0, "clear held");
      req <= 24'h0;
      repeat (4) @(posedge clk);
      rdchk(`ISDM_OFS_STICKY, (c == 3) ? 32'h0 : 32'h8, "edge off");
      wr(`ISDM_OFS_STICKY, 32'h8);
    end
    wr(`ISDM_OFS_FORCE, 32'h10);
    rdchk(`ISDM_OFS_STICKY, 32'h10, "forced");
    wr(`ISDM_OFS_STICKY, 32'h10);
    rdchk(`ISDM_OFS_STICKY, 32'h0, "forced clear");
    $display("test triggers done");
    wr(`ISDM_OFS_BYPASS, 32'h8);
    req <= 24'h8;
    repeat (4) @(posedge clk);
    chk(dst, dst_exp(24'h8), "bypass on");
    req <= 24'h0;
    repeat (4) @(posedge clk);
    chk(dst, 4'h0, "bypass off");
    req <= 24'h8;
    wr(`ISDM_OFS_ENA_CLR, 32'h8);
    repeat (4) @(posedge clk);
    chk(dst, 4'h0, "disabled");
    $display("test bypass done");
    end_sim();
  end
endmodule
bind isdm_irq_map isdm_irq_map_properties u_props (.*);
`default_nettype wire

/* File: isdm_irq_map_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module isdm_irq_map_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Destinations
  input wire logic        proc_irq_line_a,
  input wire logic        proc_irq_line_b
);
  logic wr_seen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Any write finished since reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
      wr_seen_q <= 1'h0;
    else if (s_axi_bvalid && s_axi_bready)
      wr_seen_q <= 1'h1;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returns data");
  a_quiet_dests: assert property (!wr_seen_q |-> !proc_irq_line_a && !proc_irq_line_b)
    else $error("destination raised with no mapping");
endmodule
`default_nettype wire

/* File: isdm_pkg.sv */
`default_nettype none
package isdm_pkg;

  // Internal sources, top field is bit 23
  typedef struct packed {
    logic pcie_power_irq;
    logic injection_ready_irq;
    logic extraction_ready_irq;
    logic memory_integrity_irq;
    logic time_master_sync_irq;
    logic timestamp_ready_irq;
    logic analyzer_irq;
    logic frame_dma_irq;
    logic mgmt_ctrl_b_irq;
    logic mgmt_ctrl_a_irq;
    logic parallel_pin_irq;
    logic serial_pin_irq;
    logic soft_irq_b;
    logic soft_irq_a;
    logic serial_master_irq;
    logic two_wire_irq;
    logic second_serial_port_irq;
    logic first_serial_port_irq;
    logic gp_tmr_c_irq;
    logic gp_tmr_b_irq;
    logic gp_tmr_a_irq;
  } isdm_int_src_t;

  // Whole block state
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [23:0]          bypass;
    logic [23:0]          trig_lo;
    logic [23:0]          trig_hi;
    logic [23:0]          sticky;
    logic [23:0]          ena;
    logic [23:0]          prev;
    logic [3:0][23:0]     map;
    logic [31:0]          dev_pol;
    logic [31:0]          dev_bypass;
    logic [31:0]          dev_trig_lo;
    logic [31:0]          dev_trig_hi;
    logic [31:0]          dev_sticky;
    logic [31:0]          dev_ena;
    logic [31:0]          dev_prev;
    logic [1:0]           ext_src_pol;
    logic [1:0]           ext_dst_pol;
    logic [3:0]           dst;
    logic [1:0]           ext_pin;
  } isdm_state_t;

endpackage
`default_nettype wire

/* File: isdm_regs.svh */
// How it works
// - Source bit 0 is high when any port module has an active enabled interrupt.
// - External input sources sit at bits 1 and 2, in that order.
// - General timers a, b, c sit at bits 3, 4 and 5.
// - First serial port at bit 6, second serial port at bit 7.
// - Two-wire interface interrupt sits at bit 8.
// - Serial master controller interrupt sits at bit 9.
// - Software interrupts a and b sit at bits 10 and 11.
// - Serial pin controller interrupt sits at bit 12.
// - Parallel pin interrupt sits at bit 13.
// - Management controllers a and b sit at bits 14 and 15.
// - Frame DMA interrupt sits at bit 16.
// - Frame analyzer interrupt sits at bit 17.
// - Timestamp ready at bit 18, time master sync at bit 19.
// - Memory integrity monitor interrupt sits at bit 20.
// - Extraction ready at bit 21, injection ready at bit 22.
// - PCIe power management interrupt sits at bit 23, the top bit.
// - Processor interrupt lines are destinations 0 and 1.
// - External interrupt outputs are destinations 2 and 3.
// - Everything inside the controller is active high.
// - Source polarity is corrected before entering the controller.
// - Destination polarity is applied after leaving the controller.
// - Level mode sets sticky while active; edge modes set on chosen transition.
// - Writing one clears sticky; a live level or new edge sets it again.
// - An enabled latched source reaches a destination only if its map bit is set.
// - Bypass uses the live source instead of sticky and ignores trigger.
`ifndef ISDM_REGS_SVH
`define ISDM_REGS_SVH

// Register offsets
`define ISDM_OFS_RAW         8'h00
`define ISDM_OFS_BYPASS      8'h04
`define ISDM_OFS_TRIG_LO     8'h08
`define ISDM_OFS_TRIG_HI     8'h0c
`define ISDM_OFS_FORCE       8'h10
`define ISDM_OFS_STICKY      8'h14
`define ISDM_OFS_ENA         8'h18
`define ISDM_OFS_ENA_CLR     8'h1c
`define ISDM_OFS_ENA_SET     8'h20
`define ISDM_OFS_IDENT       8'h24
`define ISDM_OFS_MAP0        8'h28
`define ISDM_OFS_DIDENT0     8'h38
`define ISDM_OFS_DEV_POL     8'h48
`define ISDM_OFS_DEV_RAW     8'h4c
`define ISDM_OFS_DEV_BYPASS  8'h50
`define ISDM_OFS_DEV_TRIG_LO 8'h54
`define ISDM_OFS_DEV_TRIG_HI 8'h58
`define ISDM_OFS_DEV_STICKY  8'h5c
`define ISDM_OFS_DEV_ENA     8'h60
`define ISDM_OFS_DEV_IDENT   8'h64
`define ISDM_OFS_EXT_SRC_POL 8'h68
`define ISDM_OFS_EXT_DST_POL 8'h6c
`define ISDM_OFS_STEP        8'h04

// Source bit positions
`define ISDM_BIT_PORT_AGG  0
`define ISDM_BIT_EXT_A     1
`define ISDM_BIT_EXT_B     2
`define ISDM_BIT_TMR_A     3
`define ISDM_BIT_TMR_B     4
`define ISDM_BIT_TMR_C     5
`define ISDM_BIT_SER_A     6
`define ISDM_BIT_SER_B     7
`define ISDM_BIT_TWO_WIRE  8
`define ISDM_BIT_SER_MST   9
`define ISDM_BIT_SOFT_A    10
`define ISDM_BIT_SOFT_B    11
`define ISDM_BIT_SER_PIN   12
`define ISDM_BIT_PAR_PIN   13
`define ISDM_BIT_MGMT_A    14
`define ISDM_BIT_MGMT_B    15
`define ISDM_BIT_FRAME_DMA_IRQ      16
`define ISDM_BIT_ANALYZER  17
`define ISDM_BIT_TS_RDY    18
`define ISDM_BIT_TM_SYNC   19
`define ISDM_BIT_MEM_INTEG 20
`define ISDM_BIT_EXTRACTION_READY_IRQ   21
`define ISDM_BIT_INJECTION_READY_IRQ   22
`define ISDM_BIT_PCIE_PM   23

// Destination indices
`define ISDM_DST_PROC_A 0
`define ISDM_DST_PROC_B 1
`define ISDM_DST_EXT_A  2
`define ISDM_DST_EXT_B  3

// Bus responses
`define ISDM_RESP_OKAY   2'h0
`define ISDM_RESP_SLVERR 2'h2

`endif
